// file: cst_supervisor.v
// Charger supervisory timing: adapter switch, overcurrent, bus, watchdog
`timescale 1ns/1ns
`include "cst_defines.vh"
// Operation
// - First insertion or option 0: 150 ms deglitch
// - Later insertion with option 1: 1.3 s
// - Adapter falling turns switch off within 3 us
// - Overcurrent held 12 ms latches switch off
// - Clock low past timeout resets bus
// - Stretch limits 10 ms master, 25 ms slave
// - Watchdog reset deglitched at least 10 ms
// - Two-bit watchdog period, default 175 s
// - 20 ns dead time setting; both drivers stay off 30 ns between them
// - Charge current lowered as system load rises
// - Hybrid boost when demand exceeds adapter
// - Hot alert on overcurrent or source removal
// - Host sets limits and alert profile
// - Automatic source selection, separate drivers
// - Wake and talk after leaving lockout
// - Expired watchdog stops charging
// - Status bit shows deglitched adapter good
module cst_supervisor #(
  parameter [35:0] ADAPTER_GOOD_SHORT_CYC = 36'd15000000,
  parameter [35:0] ADAPTER_GOOD_LONG_CYC = 36'd130000000,
  parameter [35:0] OC_CYC = 36'd1200000,
  parameter [35:0] SCL_TO_CYC = 36'd3000000,
  parameter [35:0] BOOT_CYC = 36'd1000000,
  parameter [35:0] WD0_CYC = 36'd500000000,
  parameter [35:0] WD1_CYC = 36'd8800000000,
  parameter [35:0] WD2_CYC = 36'd17500000000
) (
  input wire clk,
  input wire srst,
  input wire supply_ok,
  input wire adapter_detect_input,
  input wire input_overcurrent,
  input wire system_overload,
  input wire battery_present,
  input wire scl_in,
  input wire watchdog_kick,
  input wire deglitch_sel,
  input wire watchdog_en,
  input wire [1:0] watchdog_period,
  input wire watchdog_period_we,
  input wire charge_req,
  input wire pwm_req,
  input wire [6:0] charge_limit,
  input wire [6:0] load_level,
  output reg adapter_good,
  output reg adapter_power_switch,
  output reg battery_switch,
  output reg bus_reset,
  output reg charge_en,
  output reg [6:0] charge_cmd,
  output reg hybrid_boost,
  output reg processor_hot_alert,
  output reg watchdog_expired,
  output reg high_drv,
  output reg low_drv,
  output reg awake
);
  localparam DT = `CST_DEAD_CYC;
  wire sup_s, det_s, oc_s, ovl_s, bat_s, scl_s, kick_s;
  wire adapter_good_deg, oc_deg, kick_deg;
  reg first_done_q;
  reg latch_q;
  reg sup_prev_q, bat_prev_q, adapter_good_prev_q;
  reg [1:0] wd_sel_q;
  reg [35:0] wd_cnt_q, scl_cnt_q;
  reg kick_prev_q;
  reg [3:0] dt_cnt_q;
  reg pwm_prev_q;

  cst_sync u_s0 (.clk(clk), .srst(srst), .d(supply_ok), .q(sup_s));
  cst_sync u_s1 (.clk(clk), .srst(srst), .d(adapter_detect_input),
    .q(det_s));
  cst_sync u_s2 (.clk(clk), .srst(srst), .d(input_overcurrent), .q(oc_s));
  cst_sync u_s3 (.clk(clk), .srst(srst), .d(system_overload), .q(ovl_s));
  cst_sync u_s4 (.clk(clk), .srst(srst), .d(battery_present), .q(bat_s));
  cst_sync u_s5 (.clk(clk), .srst(srst), .d(scl_in), .q(scl_s));
  cst_sync u_s6 (.clk(clk), .srst(srst), .d(watchdog_kick), .q(kick_s));

  function [35:0] wd_limit;
    input [1:0] code;
    begin
      case (code)
        2'h0: wd_limit = WD0_CYC;
        2'h1: wd_limit = WD0_CYC;
        2'h2: wd_limit = WD1_CYC;
        default: wd_limit = WD2_CYC;
      endcase
    end
  endfunction

  // Falling edge clears at once: two sync flops plus one = 30 ns
  cst_deglitch u_adapter_good (.clk(clk), .srst(srst), .in(det_s && sup_s),
    .limit((!first_done_q || !deglitch_sel) ? ADAPTER_GOOD_SHORT_CYC :
    ADAPTER_GOOD_LONG_CYC), .out(adapter_good_deg));
  cst_deglitch u_oc (.clk(clk), .srst(srst), .in(oc_s), .limit(OC_CYC),
    .out(oc_deg));
  cst_deglitch u_kick (.clk(clk), .srst(srst), .in(kick_s),
    .limit(BOOT_CYC), .out(kick_deg));

  always @(posedge clk) begin
    if (srst) begin
      first_done_q <= 1'b0;
      latch_q <= 1'b0;
      sup_prev_q <= 1'b0;
      bat_prev_q <= 1'b0;
      adapter_good_prev_q <= 1'b0;
      adapter_good <= 1'b0;
      adapter_power_switch <= 1'b0;
      battery_switch <= 1'b0;
      awake <= 1'b0;
      processor_hot_alert <= 1'b0;
    end else begin
      sup_prev_q <= sup_s;
      bat_prev_q <= bat_s;
      adapter_good_prev_q <= adapter_good_deg;
      awake <= sup_s;
      adapter_good <= adapter_good_deg;
      if (sup_s && !sup_prev_q)
        first_done_q <= 1'b0;
      else if (adapter_good_deg && !adapter_good_prev_q)
        first_done_q <= 1'b1;
      if (oc_deg)
        latch_q <= 1'b1;
      else if (!det_s)
        latch_q <= 1'b0;
      adapter_power_switch <= adapter_good_deg && !latch_q && !oc_deg;
      battery_switch <= sup_s && bat_s && !adapter_good_deg;
      processor_hot_alert <= oc_s || ovl_s ||
        (adapter_good_prev_q && !adapter_good_deg) || (bat_prev_q && !bat_s);
    end
  end

  // Bus clock-low timeout; 30 ms, shorter than the 35 ms combined stretch of both parties
  always @(posedge clk) begin
    if (srst || scl_s || !sup_s) begin
      scl_cnt_q <= 36'h0;
      bus_reset <= 1'b0;
    end else if (scl_cnt_q >= SCL_TO_CYC) begin
      bus_reset <= 1'b1;
    end else begin
      scl_cnt_q <= scl_cnt_q + 36'h1;
    end
  end

  // Watchdog
  always @(posedge clk) begin
    if (srst) begin
      wd_sel_q <= `CST_WD_CODE_RESET;
      wd_cnt_q <= 36'h0;
      kick_prev_q <= 1'b0;
      watchdog_expired <= 1'b0;
    end else begin
      kick_prev_q <= kick_deg;
      if (watchdog_period_we)
        wd_sel_q <= watchdog_period;
      if (!watchdog_en || (kick_deg && !kick_prev_q)) begin
        wd_cnt_q <= 36'h0;
        watchdog_expired <= 1'b0;
      end else if (wd_cnt_q >= wd_limit(wd_sel_q)) begin
        watchdog_expired <= 1'b1;
      end else begin
        wd_cnt_q <= wd_cnt_q + 36'h1;
      end
    end
  end

  // Charge control with load-based derating
  always @(posedge clk) begin
    if (srst) begin
      charge_en <= 1'b0;
      charge_cmd <= 7'h00;
      hybrid_boost <= 1'b0;
    end else begin
      charge_en <= charge_req && adapter_power_switch &&
        !watchdog_expired && !latch_q;
      if (load_level >= charge_limit)
        charge_cmd <= 7'h00;
      else
        charge_cmd <= charge_limit - load_level;
      hybrid_boost <= adapter_good_deg && bat_s && ovl_s;
    end
  end

  // Break-before-make PWM drivers
  always @(posedge clk) begin
    if (srst) begin
      high_drv <= 1'b0;
      low_drv <= 1'b0;
      dt_cnt_q <= 4'h0;
      pwm_prev_q <= 1'b0;
    end else begin
      pwm_prev_q <= pwm_req;
      if (pwm_req != pwm_prev_q) begin
        high_drv <= 1'b0;
        low_drv <= 1'b0;
        dt_cnt_q <= 4'h0;
      end else if (dt_cnt_q < DT[3:0]) begin
        dt_cnt_q <= dt_cnt_q + 4'h1;
      end else begin
        high_drv <= pwm_req && charge_en;
        low_drv <= !pwm_req && charge_en;
      end
    end
  end
endmodule

// file: cst_defines.vh
// Timing constants and watchdog reset code for the charger supervisor
`ifndef CST_DEFINES_VH
`define CST_DEFINES_VH
`define CST_CLK_MHZ 100
`define CST_CLK_HZ 100000000
`define CST_ADAPTER_GOOD_SHORT_MS 150
`define CST_ADAPTER_GOOD_LONG_MS 1300
`define CST_FALL_US 3
`define CST_OC_MS 12
`define CST_SCL_TO_MS 30
`define CST_BOOT_MS 10
`define CST_WD_CODE_RESET 2'h3
`define CST_WD_P0_S 5
`define CST_WD_P1_S 88
`define CST_WD_P2_S 175
`define CST_DEAD_NS 20
`define CST_DEAD_CYC ((`CST_DEAD_NS * `CST_CLK_MHZ + 999) / 1000)
`define CST_CNT_W 36
`endif

// file: cst_sync.v
// Two-flop synchroniser for asynchronous pins
`timescale 1ns/1ns
module cst_sync (
  input wire clk,
  input wire srst,
  input wire d,
  output reg q
);
  reg m_q;
  always @(posedge clk) begin
    if (srst) begin
      m_q <= 1'b0;
      q <= 1'b0;
    end else begin
      m_q <= d;
      q <= m_q;
    end
  end
endmodule

// file: cst_deglitch.v
// Holds a high level for a programmable count before passing it on; a low clears at once
`timescale 1ns/1ns
module cst_deglitch (
  input wire clk,
  input wire srst,
  input wire in,
  input wire [35:0] limit,
  output reg out
);
  reg [35:0] cnt_q;
  always @(posedge clk) begin
    if (srst || !in) begin
      cnt_q <= 36'h0;
      out <= 1'b0;
    end else if (cnt_q >= limit) begin
      out <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 36'h1;
    end
  end
endmodule

// file: cst_sup_monitor.sv
// Port checker for the charger supervisor
`timescale 1ns/1ns
module cst_sup_monitor #(
  parameter [35:0] ADAPTER_GOOD_SHORT_CYC = 36'h28,
  parameter [35:0] OC_CYC = 36'h3c,
  parameter [35:0] SCL_TO_CYC = 36'h50
) (
  input wire clk,
  input wire srst,
  input wire adapter_detect_input,
  input wire input_overcurrent,
  input wire scl_in,
  input wire adapter_good,
  input wire adapter_power_switch,
  input wire bus_reset,
  input wire charge_en,
  input wire watchdog_expired,
  input wire high_drv,
  input wire low_drv
);
  reg [35:0] hi_q;
  reg [35:0] oc_q;
  reg [35:0] lo_q;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  always @(posedge clk) begin
    hi_q <= (srst || !adapter_detect_input) ? 36'h0 : hi_q + 36'h1;
    oc_q <= (srst || !input_overcurrent) ? 36'h0 : oc_q + 36'h1;
    lo_q <= (srst || scl_in) ? 36'h0 : lo_q + 36'h1;
  end
  a_good_min_hold: assert property ($rose(adapter_good) |->
    hi_q >= ADAPTER_GOOD_SHORT_CYC) else $error("good rose early");
  a_switch_after_good: assert property ($rose(adapter_power_switch) |->
    adapter_good) else $error("switch without good");
  a_fall_off: assert property (!adapter_detect_input [*6] |->
    !adapter_power_switch) else $error("switch slow off");
  a_oc_latch: assert property (oc_q > OC_CYC + 36'h6 |->
    !adapter_power_switch) else $error("overcurrent not latched");
  a_bus_timeout: assert property ($rose(bus_reset) |->
    lo_q >= SCL_TO_CYC) else $error("bus reset early");
  a_dead_rise: assert property ($rose(high_drv) |->
    !$past(low_drv) && !$past(low_drv, 2)) else $error("dead time high");
  a_dead_fall: assert property ($rose(low_drv) |->
    !$past(high_drv) && !$past(high_drv, 2)) else $error("dead time low");
  a_wd_stops: assert property (watchdog_expired |=>
    !charge_en) else $error("charge after expiry");
  c_good: cover property ($rose(adapter_good));
  c_bus: cover property ($rose(bus_reset));
  c_wd: cover property ($rose(watchdog_expired));
endmodule
bind cst_supervisor cst_sup_monitor #(.ADAPTER_GOOD_SHORT_CYC(ADAPTER_GOOD_SHORT_CYC),
  .OC_CYC(OC_CYC), .SCL_TO_CYC(SCL_TO_CYC)) i_cst_sup_monitor (.clk,
  .srst, .adapter_detect_input, .input_overcurrent, .scl_in, .adapter_good,
  .adapter_power_switch, .bus_reset, .charge_en, .watchdog_expired,
  .high_drv, .low_drv);

// file: cst_host_model.sv
// Host bus clock: idles high, toggles in frames, may hold low
`timescale 1ns/1ns
module cst_host_model (
  input wire clk,
  input wire active,
  input wire stall,
  output reg scl
);
  reg [3:0] div_q = 4'h0;
  initial scl = 1'b1;
  always @(posedge clk) begin
    div_q <= div_q + 4'h1;
    if (stall)
      scl <= 1'b0;
    else if (!active)
      scl <= 1'b1;
    else if (div_q == 4'hf)
      scl <= ~scl;
  end
endmodule

// file: tb_charger_supervisor_timing.sv
// Self-checking bench for the charger supervisor
`timescale 1ns/1ns
module tb_charger_supervisor_timing;
  reg clk = 0, srst = 1, sup = 0, det = 0, oc = 0, act = 0, stall = 0;
  reg sel = 0, wen = 0, we = 0, chg = 0, pwm = 0;
  reg ovl = 0, bat = 1, kick = 0;
  wire bsw, hyb, alert, hdrv, ldrv, awk;
  wire [6:0] ccmd;
  reg [1:0] per = 2'h0;
  wire scl, good, sw, bres, cen, wexp;
  integer n_errors = 0, cmp_count = 0, cyc = 0, n;
  initial forever #5 clk = ~clk;
  cst_host_model i_cst_host_model (.clk(clk), .active(act), .stall(stall),
    .scl(scl));
  cst_supervisor #(.ADAPTER_GOOD_SHORT_CYC(36'h28), .ADAPTER_GOOD_LONG_CYC(36'h78),
    .OC_CYC(36'h3c), .SCL_TO_CYC(36'h50), .BOOT_CYC(36'h14),
    .WD0_CYC(36'h12c), .WD1_CYC(36'h190), .WD2_CYC(36'h1f4))
    i_cst_supervisor (.clk(clk), .srst(srst), .supply_ok(sup),
    .adapter_detect_input(det), .input_overcurrent(oc),
    .system_overload(ovl), .battery_present(bat), .scl_in(scl),
    .watchdog_kick(kick), .deglitch_sel(sel), .watchdog_en(wen),
    .watchdog_period(per), .watchdog_period_we(we), .charge_req(chg),
    .pwm_req(pwm), .charge_limit(7'h40), .load_level(7'h10),
    .adapter_good(good), .adapter_power_switch(sw), .battery_switch(bsw),
    .bus_reset(bres), .charge_en(cen), .charge_cmd(ccmd),
    .hybrid_boost(hyb), .processor_hot_alert(alert),
    .watchdog_expired(wexp), .high_drv(hdrv), .low_drv(ldrv),
    .awake(awk));
  task chkv(input string nm, input logic [6:0] e, input logic [6:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s exp %h got %h", nm, e, g);
    end
  endtask
  task chk(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s exp %b got %b", nm, e, g);
    end
  endtask
  task chkr(input string nm, input integer lo, input integer hi);
    cmp_count++;
    if (n < lo || n > hi) begin
      n_errors++;
      $display("Error %s exp %0d..%0d got %0d", nm, lo, hi, n);
    end
  endtask
  task print_verdict;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task t_insert(input logic s, input integer lim);
    @(posedge clk);
    det <= 1'b1;
    sel <= s;
    n = 0;
    while (good !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
    chkr("good delay", lim, lim + 10);
    chk("awake", 1'b1, awk);
    chk("battery switch off", 1'b0, bsw);
    @(posedge clk);
    #1 chk("switch on", 1'b1, sw);
  endtask
  task t_remove;
    @(posedge clk);
    det <= 1'b0;
    n = 0;
    while (sw !== 1'b0 && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
    chkr("switch off", 0, 5);
    repeat (6) @(posedge clk);
    #1 chk("battery switch on", 1'b1, bsw);
  endtask
  task t_oc;
    @(posedge clk);
    oc <= 1'b1;
    n = 0;
    while (sw !== 1'b0 && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
    chkr("oc delay", 60, 72);
    chk("hot alert", 1'b1, alert);
    oc <= 1'b0;
    repeat (20) @(posedge clk);
    #1 chk("oc latch", 1'b0, sw);
  endtask
  task t_bus;
    @(posedge clk);
    act <= 1'b1;
    repeat (100) @(posedge clk);
    stall <= 1'b1;
    n = 0;
    while (bres !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
    chkr("bus reset", 80, 92);
    stall <= 1'b0;
    act <= 1'b0;
  endtask
  task t_wd;
    @(posedge clk);
    chg <= 1'b1;
    wen <= 1'b1;
    ovl <= 1'b1;
    n = 0;
    while (wexp !== 1'b1 && n < 2000) begin
      @(posedge clk);
      pwm <= n[3];
      #1 n++;
      chk("drivers overlap", 1'b0, hdrv && ldrv);
      if (n == 6)
        chk("low drive", 1'b1, ldrv);
      if (n == 14)
        chk("high drive", 1'b1, hdrv);
    end
    chkr("wd period", 495, 540);
    chk("hybrid boost", 1'b1, hyb);
    chkv("charge cmd", 7'h30, ccmd);
    ovl <= 1'b0;
    @(posedge clk);
    #1 chk("charge stop", 1'b0, cen);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    sup <= 1'b1;
    t_insert(1'b1, 40);
    t_remove;
    t_insert(1'b1, 120);
    t_remove;
    t_insert(1'b0, 40);
    t_oc;
    t_remove;
    t_bus;
    t_insert(1'b0, 40);
    t_wd;
    print_verdict;
  end
endmodule
